// File: flash_pkg.sv
// Constants for the flash status, OTP and identifier read-out block.
// Assumes a word-addressed x16 flash bus and a 100 MHz system clock.
package flash_pkg;

  // Bus widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OFS_W  = 16;

  // Command codes taken from the low data byte of a bus write
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_PROG    = 8'h40;
  localparam logic [7:0] CMD_WORD_PROG_2  = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK   = 8'h01;
  localparam logic [7:0] CMD_LOCK_DOWN    = 8'h2F;
  localparam logic [7:0] CMD_OTP_PROG     = 8'hC0;

  // Identifier space offsets, low 16 address bits
  localparam logic [15:0] OFS_MAKER      = 16'h0000;
  localparam logic [15:0] OFS_PART       = 16'h0001;
  localparam logic [15:0] OFS_BLOCK_LOCK = 16'h0002;
  localparam logic [15:0] OFS_CONFIG     = 16'h0005;
  localparam logic [15:0] OFS_LOCK0      = 16'h0080;
  localparam logic [15:0] OFS_OTP0_LO    = 16'h0081;
  localparam logic [15:0] OFS_OTP0_HI    = 16'h0088;
  localparam logic [15:0] OFS_LOCK1      = 16'h0089;
  localparam logic [15:0] OFS_OTPX_LO    = 16'h008A;
  localparam logic [15:0] OFS_OTPX_HI    = 16'h0109;

  // OTP storage: 17 registers of 8 words each
  localparam int OTP_REGS      = 17;
  localparam int OTP_WORDS     = 136;
  localparam int OTP_IDX_W     = 8;
  localparam int FACTORY_WORDS = 4;
  localparam int REG_WORDS     = 8;

  // Reset and erased values
  localparam logic [7:0]  SR_RESET     = 8'h80;
  localparam logic [7:0]  LOCK0_RESET  = 8'hFE;
  localparam logic [15:0] LOCK1_RESET  = 16'hFFFF;
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
  localparam logic [7:0]  LOCK0_USER_M = 8'h02;
  localparam logic [7:0]  CONFIG_RESET = 8'h00;

  // Status bit positions and masks
  localparam int SR_READY      = 7;
  localparam int SR_ERASE_PAUS = 6;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_PROG_FAIL  = 4;
  localparam int SR_VOLT_FAIL  = 3;
  localparam int SR_PROG_PAUS  = 2;
  localparam int SR_LOCKED_TGT = 1;
  localparam logic [7:0] ERR_MASK = 8'h3A;
  localparam logic [7:0] ERR_SEQ  = 8'h30;

  // Query space bytes
  localparam logic [7:0] QRY_OFS0 = 8'h10;
  localparam logic [7:0] QRY_OFS1 = 8'h11;
  localparam logic [7:0] QRY_OFS2 = 8'h12;
  localparam logic [7:0] QRY_CH0  = 8'h51;
  localparam logic [7:0] QRY_CH1  = 8'h52;
  localparam logic [7:0] QRY_CH2  = 8'h59;

  // Operation times
  localparam int CLK_MHZ       = 100;
  localparam int PROG_TIME_NS  = 1000;
  localparam int ERASE_TIME_NS = 40000;
  localparam int PROG_CYC      = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYC     = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W         = 12;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_ID, MODE_QUERY} read_mode_t;
  typedef enum logic [2:0] {PEND_NONE, PEND_PROG, PEND_ERASE, PEND_LOCK, PEND_OTP} pend_t;
  typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} op_t;

endpackage

// File: flash_status_otp_id_readout.sv
// Status register, OTP protection registers, lock words and identifier /
// query read-out of a x16 NOR flash, seen from behind its bus pins.
// Assumes bus pins already synchronous to clk_sys_in; the main array is outside.
`timescale 1ns/1ns

// How it works
// - Seventeen protection registers, zero to sixteen, each 128 bits wide.
// - Register zero low 64 bits factory number; rest user programmable.
// - User bits program individually; a set lock bit rejects further programming.
// - Protection data read in identifier mode, sixteen bits per access.
// - One word per OTP program; address outside OTP space sets bit 4.
// - Lock word zero: bit 0 factory half, bit 1 user half of register zero.
// - Lock word one: bit n-1 locks register n for registers one to sixteen.
// - Program to a locked section changes nothing and sets status bits 5 and 4.
// - Program voltage below lockout refuses every array-altering operation.
// - After program, erase or lock sequences reads return status until new command.
// - Status read single accesses only; status on low byte, zero high byte.
// - Status latched on first falling edge of output or chip enable.
// - Bit 7 zero while busy, one when ready; reset value 0x80.
// - Bit 5 erase fail, bit 4 program fail, both set together for a sequence error.
// - Bit 3 low program voltage, bit 1 locked target, operation aborted.
// - Bit 6 erase paused, bit 2 program paused, bit 0 always zero (no buffered programming).
// - Sequencer sets and clears bits 7,6,2; only sets errors; clear command clears.
// - Identifier map: maker, part, block lock, config, lock words, OTP data.
// - Identifier reads put data on low byte, upper byte zero, except lock word one and OTP data (16 bits).
// - Query data only for single-word reads after the query command.
module flash_status_otp_id_readout
  import flash_pkg::*;
#(
  parameter logic [7:0]  MAKER_CODE = 8'hA5,                  // Arbitrary value
  parameter logic [7:0]  PART_CODE  = 8'h5C,                  // Arbitrary value
  parameter logic [63:0] UNIQUE_ID  = 64'h0123_4567_89AB_CDEF // Arbitrary value
) (
  input  wire logic                  clk_sys_in,   // System clock
  input  wire logic                  rst_in,       // Async reset, high
  input  wire logic                  ce_n_in,      // Chip enable, low
  input  wire logic                  oe_n_in,      // Output enable, low
  input  wire logic                  we_n_in,      // Write enable, low
  input  wire logic [ADDR_W-1:0]     addr_in,      // Word address
  input  wire logic [DATA_W-1:0]     data_in,      // Write data
  output logic      [DATA_W-1:0]     data_out,     // Read data
  output logic                       data_oe_n_out,// Data drive enable, low
  input  wire logic                  pgm_volt_ok_in,// Program voltage above lockout
  input  wire logic                  blk_locked_in, // Addressed block locked
  input  wire logic                  blk_lockdn_in, // Addressed block locked down
  input  wire logic [DATA_W-1:0]     array_data_in  // Main array read data
);
  import flash_pkg::*;

  // Map an identifier offset onto an OTP word index
  function automatic logic otp_hit(input logic [OFS_W-1:0] ofs);
    otp_hit = (ofs >= OFS_OTP0_LO && ofs <= OFS_OTP0_HI) ||
              (ofs >= OFS_OTPX_LO && ofs <= OFS_OTPX_HI);
  endfunction

  function automatic logic [OTP_IDX_W-1:0] otp_idx(input logic [OFS_W-1:0] ofs);
    logic [OFS_W-1:0] d;
    d = (ofs <= OFS_OTP0_HI) ? (ofs - OFS_OTP0_LO) : (ofs - OFS_OTPX_LO + 16'd8);
    otp_idx = d[OTP_IDX_W-1:0];
  endfunction

  // Query space: only the signature bytes are held here
  function automatic logic [7:0] query_byte(input logic [7:0] ofs);
    case (ofs)
      QRY_OFS0: query_byte = QRY_CH0;
      QRY_OFS1: query_byte = QRY_CH1;
      QRY_OFS2: query_byte = QRY_CH2;
      default:  query_byte = 8'h00;
    endcase
  endfunction

  read_mode_t             mode_q, mode_d;
  pend_t                  pend_q, pend_d;
  op_t                    op_q, op_start;
  logic                   paused_q;
  logic [TMR_W-1:0]       tmr_q;
  logic [7:0]             err_q, err_set;
  logic                   err_clr;
  logic                   pause_req, resume_req;
  logic [7:0]             sr_now, sr_latch_q;
  logic                   held_q;
  logic                   ce_n_q, oe_n_q, we_n_q;
  logic                   wr_ev, ce_fall, oe_fall;
  logic [7:0]             cmd;
  logic [OFS_W-1:0]       ofs;
  logic [15:0]            otp_q [OTP_WORDS];
  logic [7:0]             lk0_q;
  logic [15:0]            lk1_q;
  logic                   otp_we, lk0_we, lk1_we;
  logic [OTP_IDX_W-1:0]   widx, ridx;
  logic                   wlocked;
  logic [4:0]             wreg;
  logic                   busy;
  logic [DATA_W-1:0]      rd_d, data_q;

  assign cmd  = data_in[7:0];
  assign ofs  = addr_in[OFS_W-1:0];
  assign busy = (op_q != OP_IDLE) && !paused_q;

  // Pin history for edge detection
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
    end else begin
      ce_n_q <= ce_n_in;
      oe_n_q <= oe_n_in;
      we_n_q <= we_n_in;
    end
  end

  // A write is taken on the rising write enable while chip enable is low
  assign wr_ev   = !we_n_q && we_n_in && !ce_n_in;
  assign ce_fall = ce_n_q && !ce_n_in;
  assign oe_fall = oe_n_q && !oe_n_in;

  // Lock coverage of the addressed OTP word
  assign widx = otp_idx(ofs);
  assign wreg = (widx < OTP_IDX_W'(REG_WORDS)) ? 5'd0 : 5'(widx / OTP_IDX_W'(REG_WORDS));
  always_comb begin
    if (widx < OTP_IDX_W'(FACTORY_WORDS)) begin
      wlocked = !lk0_q[0];
    end else if (widx < OTP_IDX_W'(REG_WORDS)) begin
      wlocked = !lk0_q[1];
    end else begin
      wlocked = !lk1_q[4'(wreg - 5'd1)];
    end
  end

  // Command decoder: one decision per bus write
  always_comb begin
    mode_d     = mode_q;
    pend_d     = pend_q;
    op_start   = OP_IDLE;
    err_set    = 8'h00;
    err_clr    = 1'b0;
    pause_req  = 1'b0;
    resume_req = 1'b0;
    otp_we     = 1'b0;
    lk0_we     = 1'b0;
    lk1_we     = 1'b0;
    if (wr_ev) begin
      if (pend_q != PEND_NONE) begin
        // Second cycle of a two-cycle command
        pend_d = PEND_NONE;
        mode_d = MODE_STATUS;
        case (pend_q)
          PEND_PROG: begin
            if (!pgm_volt_ok_in) begin
              err_set = 8'h18;
            end else if (blk_locked_in) begin
              err_set = 8'h12;
            end else begin
              op_start = OP_PROG;
            end
          end
          PEND_ERASE: begin
            if (cmd != CMD_CONFIRM) begin
              err_set = ERR_SEQ;
            end else if (!pgm_volt_ok_in) begin
              err_set = 8'h28;
            end else if (blk_locked_in) begin
              err_set = 8'h22;
            end else begin
              op_start = OP_ERASE;
            end
          end
          PEND_LOCK: begin
            if (cmd != CMD_LOCK_BLOCK && cmd != CMD_CONFIRM && cmd != CMD_LOCK_DOWN) begin
              err_set = ERR_SEQ;
            end
          end
          PEND_OTP: begin
            if (!pgm_volt_ok_in) begin
              err_set = 8'h18;
            end else if (ofs == OFS_LOCK0) begin
              lk0_we   = 1'b1;
              op_start = OP_PROG;
            end else if (ofs == OFS_LOCK1) begin
              lk1_we   = 1'b1;
              op_start = OP_PROG;
            end else if (!otp_hit(ofs)) begin
              err_set = 8'h10;
            end else if (wlocked) begin
              err_set = ERR_SEQ;
            end else begin
              otp_we   = 1'b1;
              op_start = OP_PROG;
            end
          end
          default: begin
          end
        endcase
      end else if (busy) begin
        // While the sequencer runs only status reads and suspend are heard
        if (cmd == CMD_READ_STATUS) begin
          mode_d = MODE_STATUS;
        end
        if (cmd == CMD_SUSPEND) begin
          pause_req = 1'b1;
          mode_d    = MODE_STATUS;
        end
      end else begin
        case (cmd)
          CMD_READ_ARRAY:   mode_d = MODE_ARRAY;
          CMD_READ_STATUS:  mode_d = MODE_STATUS;
          CMD_READ_ID:      mode_d = MODE_ID;
          CMD_READ_QUERY:   mode_d = MODE_QUERY;
          CMD_CLEAR_STATUS: err_clr = 1'b1;
          CMD_CONFIRM: begin
            if (paused_q) begin
              resume_req = 1'b1;
              mode_d     = MODE_STATUS;
            end
          end
          CMD_WORD_PROG, CMD_WORD_PROG_2: begin
            if (!paused_q) begin
              pend_d = PEND_PROG;
            end
          end
          CMD_ERASE_SETUP: begin
            if (!paused_q) begin
              pend_d = PEND_ERASE;
            end
          end
          CMD_LOCK_SETUP:   pend_d = PEND_LOCK;
          CMD_OTP_PROG: begin
            if (!paused_q) begin
              pend_d = PEND_OTP;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read mode and pending command
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= MODE_ARRAY;
      pend_q <= PEND_NONE;
    end else begin
      mode_q <= mode_d;
      pend_q <= pend_d;
    end
  end

  // Operation timer; a pause freezes it, a second pause is not nested
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      op_q     <= OP_IDLE;
      paused_q <= 1'b0;
      tmr_q    <= '0;
    end else if (op_start != OP_IDLE) begin
      op_q  <= op_start;
      tmr_q <= (op_start == OP_ERASE) ? TMR_W'(ERASE_CYC - 1) : TMR_W'(PROG_CYC - 1);
    end else if (pause_req) begin
      paused_q <= 1'b1;
    end else if (resume_req) begin
      paused_q <= 1'b0;
    end else if (busy) begin
      if (tmr_q == '0) begin
        op_q <= OP_IDLE;
      end else begin
        tmr_q <= tmr_q - TMR_W'(1);
      end
    end
  end

  // Sticky error bits; a new error in the clearing cycle survives
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      err_q <= 8'h00;
    end else begin
      err_q <= ((err_q & ~(err_clr ? ERR_MASK : 8'h00)) | err_set) & ERR_MASK;
    end
  end

  // Live status; buffered factory programming is not offered, so bit 0 stays low
  always_comb begin
    sr_now                = err_q;
    sr_now[SR_READY]      = !busy;
    sr_now[SR_ERASE_PAUS] = paused_q && (op_q == OP_ERASE);
    sr_now[SR_PROG_PAUS]  = paused_q && (op_q == OP_PROG);
    sr_now[0]             = 1'b0;
  end

  // Status snapshot taken once per access, at whichever enable falls first
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sr_latch_q <= SR_RESET;
      held_q     <= 1'b0;
    end else if ((ce_fall || oe_fall) && !held_q) begin
      sr_latch_q <= sr_now;
      held_q     <= 1'b1;
    end else if (ce_n_in && oe_n_in) begin
      held_q <= 1'b0;
    end
  end

  // OTP words: flash-style programming only clears bits
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < OTP_WORDS; i++) begin
        otp_q[i] <= (i < FACTORY_WORDS) ? UNIQUE_ID[16*(i % FACTORY_WORDS) +: 16] : ERASED_WORD;
      end
    end else if (otp_we) begin
      otp_q[widx] <= otp_q[widx] & data_in;
    end
  end

  // Lock words; only the user bit of lock word zero is writable
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      lk0_q <= LOCK0_RESET;
      lk1_q <= LOCK1_RESET;
    end else begin
      if (lk0_we) begin
        lk0_q <= lk0_q & (data_in[7:0] | ~LOCK0_USER_M);
      end
      if (lk1_we) begin
        lk1_q <= lk1_q & data_in;
      end
    end
  end

  // Read data selection
  assign ridx = otp_idx(ofs);
  always_comb begin
    rd_d = 16'h0000;
    case (mode_q)
      MODE_ARRAY:  rd_d = array_data_in;
      MODE_STATUS: rd_d = {8'h00, sr_latch_q};
      MODE_QUERY:  rd_d = {8'h00, query_byte(ofs[7:0])};
      MODE_ID: begin
        if (ofs == OFS_MAKER) begin
          rd_d = {8'h00, MAKER_CODE};
        end else if (ofs == OFS_PART) begin
          rd_d = {8'h00, PART_CODE};
        end else if (ofs == OFS_BLOCK_LOCK) begin
          rd_d = {14'h0000, blk_lockdn_in, blk_locked_in};
        end else if (ofs == OFS_CONFIG) begin
          rd_d = {8'h00, CONFIG_RESET};
        end else if (ofs == OFS_LOCK0) begin
          rd_d = {8'h00, lk0_q};
        end else if (ofs == OFS_LOCK1) begin
          rd_d = lk1_q;
        end else if (otp_hit(ofs)) begin
          rd_d = otp_q[ridx];
        end
      end
      default: rd_d = 16'h0000;
    endcase
  end

  // Registered read data; the bus drives only during an output cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      data_q <= 16'h0000;
    end else begin
      data_q <= rd_d;
    end
  end

  assign data_out      = data_q;
  assign data_oe_n_out = !(!ce_n_in && !oe_n_in && we_n_in);

endmodule

// File: readout_props.sv
// Pin-level assertions for the OTP / identifier read-out block.
// Assumes the host writes only status reads while an operation runs.
`timescale 1ns/1ns
module readout_props
  import flash_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h5C  // Arbitrary value
) (
  input wire logic              clk_sys_in,    // Clock
  input wire logic              rst_in,        // Reset
  input wire logic              ce_n_in,       // Chip enable
  input wire logic              oe_n_in,       // Output enable
  input wire logic              we_n_in,       // Write enable
  input wire logic [ADDR_W-1:0] addr_in,       // Address
  input wire logic [DATA_W-1:0] data_in,       // Write data
  input wire logic [DATA_W-1:0] data_out,      // Read data
  input wire logic              data_oe_n_out, // Drive enable
  input wire logic              blk_locked_in, // Block locked
  input wire logic              blk_lockdn_in, // Block locked down
  input wire logic [DATA_W-1:0] array_data_in  // Array data
);
  import flash_pkg::*;
  logic       we_prev_q;
  logic       pend_q;
  read_mode_t mode_q;
  logic       wr_tk;
  logic       rd_c;
  // A write lands on the rising edge of the write strobe
  assign wr_tk = we_n_in & ~we_prev_q & ~ce_n_in;
  assign rd_c  = ~ce_n_in & ~oe_n_in & we_n_in;
  // Previous strobe level
  always_ff @(posedge clk_sys_in or posedge rst_in)
    if (rst_in) we_prev_q <= 1'b1;
    else we_prev_q <= we_n_in;
  // Setup writes swallow the next write, whatever it is
  always_ff @(posedge clk_sys_in or posedge rst_in)
    if (rst_in) pend_q <= 1'b0;
    else if (wr_tk) pend_q <= ~pend_q & (data_in[7:0] inside {CMD_OTP_PROG, CMD_WORD_PROG,
                                          CMD_WORD_PROG_2, CMD_ERASE_SETUP, CMD_LOCK_SETUP});
  // Read mode as the host has set it; a finished sequence falls back to status
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) mode_q <= MODE_ARRAY;
    else if (wr_tk && pend_q) mode_q <= MODE_STATUS;
    else if (wr_tk) begin
      case (data_in[7:0])
        CMD_READ_ARRAY:  mode_q <= MODE_ARRAY;
        CMD_READ_STATUS: mode_q <= MODE_STATUS;
        CMD_READ_ID:     mode_q <= MODE_ID;
        CMD_READ_QUERY:  mode_q <= MODE_QUERY;
        default:         mode_q <= mode_q;
      endcase
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_oe_decode;
    data_oe_n_out == ~rd_c;
  endproperty
  a_oe_decode: assert property (p_oe_decode) else $error("data drive enable wrong");
  property p_status_hi;
    (mode_q == MODE_STATUS && rd_c) ##1 rd_c |-> data_out[15:8] == 8'h00;
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status high byte not zero");
  property p_maker;
    (mode_q == MODE_ID && rd_c && addr_in[15:0] == OFS_MAKER) |=> data_out == {8'h00, MAKER_CODE};
  endproperty
  a_maker: assert property (p_maker) else $error("maker code wrong");
  property p_part;
    (mode_q == MODE_ID && rd_c && addr_in[15:0] == OFS_PART) |=> data_out == {8'h00, PART_CODE};
  endproperty
  a_part: assert property (p_part) else $error("part code wrong");
  property p_blk;
    (mode_q == MODE_ID && rd_c && addr_in[15:0] == OFS_BLOCK_LOCK)
      |=> data_out == {14'h0000, $past(blk_lockdn_in), $past(blk_locked_in)};
  endproperty
  a_blk: assert property (p_blk) else $error("block lock word wrong");
  property p_id_hi;
    (mode_q == MODE_ID && rd_c && addr_in[15:0] < OFS_OTP0_LO) |=> data_out[15:8] == 8'h00;
  endproperty
  a_id_hi: assert property (p_id_hi) else $error("identifier high byte not zero");
  property p_lock0;
    (mode_q == MODE_ID && rd_c && addr_in[15:0] == OFS_LOCK0) |=> data_out[0] == 1'b0;
  endproperty
  a_lock0: assert property (p_lock0) else $error("factory lock bit not set");
  property p_query;
    (mode_q == MODE_QUERY && rd_c && addr_in[15:0] == {8'h00, QRY_OFS0}) |=> data_out == {8'h00, QRY_CH0};
  endproperty
  a_query: assert property (p_query) else $error("query byte wrong");
  property p_array;
    (mode_q == MODE_ARRAY && rd_c) |=> data_out == $past(array_data_in);
  endproperty
  a_array: assert property (p_array) else $error("array data wrong");
  c_id: cover property (mode_q == MODE_ID && rd_c);
  c_query: cover property (mode_q == MODE_QUERY && rd_c);
  c_status: cover property (mode_q == MODE_STATUS && rd_c);
endmodule

bind flash_status_otp_id_readout readout_props #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) readout_props_i (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_n_in(ce_n_in), .oe_n_in(oe_n_in), .we_n_in(we_n_in),
  .addr_in(addr_in), .data_in(data_in), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
  .blk_locked_in(blk_locked_in), .blk_lockdn_in(blk_lockdn_in), .array_data_in(array_data_in));

// File: host_model.sv
// Host memory controller on the parallel flash bus, driven by task calls.
// Assumes the device samples the pins on the rising clock edge.
`timescale 1ns/1ns
module host_model
  import flash_pkg::*;
(
  input  wire logic              clk_sys_in, // Clock
  input  wire logic [DATA_W-1:0] rdata_in,   // Device read data
  output logic                   ce_n_out,   // Chip enable
  output logic                   oe_n_out,   // Output enable
  output logic                   we_n_out,   // Write enable
  output logic [ADDR_W-1:0]      addr_out,   // Address
  output logic [DATA_W-1:0]      wdata_out   // Write data
);
  // Bus idle at time zero
  initial begin
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
    we_n_out = 1'b1;
    addr_out = 24'h000000;
    wdata_out = 16'h0000;
  end
  // One write: strobe low for a cycle, then high with chip enable still low
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_sys_in);
    ce_n_out = 1'b0;
    we_n_out = 1'b0;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_sys_in);
    we_n_out = 1'b1;
    @(negedge clk_sys_in);
    ce_n_out = 1'b1;
    wdata_out = ~d; // Released bus must not keep showing the last word
  endtask
  // Single-word read only; both enables go high again before the next one
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
    @(negedge clk_sys_in);
    ce_n_out = 1'b0;
    oe_n_out = 1'b0;
    addr_out = a;
    repeat (2) @(negedge clk_sys_in);
    q = rdata_in;
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
    @(negedge clk_sys_in);
  endtask
endmodule

// File: flash_status_otp_id_readout_test.sv
// Self-checking bench for the OTP / identifier read-out block.
// Assumes the host model drives all bus pins on the falling clock edge.
`timescale 1ns/1ns
module flash_status_otp_id_readout_test;
  import flash_pkg::*;
  localparam logic [7:0]  MAKER = 8'hA5;                 // Arbitrary value
  localparam logic [7:0]  PART  = 8'h5C;                 // Arbitrary value
  localparam logic [63:0] UID   = 64'h0123_4567_89AB_CDEF; // Arbitrary value
  typedef struct packed {logic [7:0] cmd; logic [23:0] a; logic lk; logic ld; logic [15:0] e;} row_t;
  logic              clk_sys_in = 1'b0;
  logic              rst_in;
  logic              ce_n, oe_n, we_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, got;
  logic              pgm_volt_ok_in, blk_locked_in, blk_lockdn_in;
  logic [DATA_W-1:0] array_data_in;
  int                num_errors = 0;
  int                comparisons = 0;
  row_t              rows [19] = '{
    '{8'h70, 24'h000000, 1'b0, 1'b0, {8'h00, SR_RESET}},
    '{8'h90, 24'h000000, 1'b0, 1'b0, {8'h00, MAKER}},
    '{8'h90, 24'h000001, 1'b0, 1'b0, {8'h00, PART}},
    '{8'h90, 24'h000002, 1'b1, 1'b0, 16'h0001},
    '{8'h90, 24'h010002, 1'b0, 1'b1, 16'h0002},
    '{8'h90, 24'h000005, 1'b0, 1'b0, {8'h00, CONFIG_RESET}},
    '{8'h90, 24'h000080, 1'b0, 1'b0, {8'h00, LOCK0_RESET}},
    '{8'h90, 24'h000081, 1'b0, 1'b0, UID[15:0]},
    '{8'h90, 24'h000082, 1'b0, 1'b0, UID[31:16]},
    '{8'h90, 24'h000083, 1'b0, 1'b0, UID[47:32]},
    '{8'h90, 24'h000084, 1'b0, 1'b0, UID[63:48]},
    '{8'h90, 24'h000088, 1'b0, 1'b0, 16'hFFFF},
    '{8'h90, 24'h000089, 1'b0, 1'b0, 16'hFFFF},
    '{8'h90, 24'h000109, 1'b0, 1'b0, 16'hFFFF},
    '{8'h98, 24'h000010, 1'b0, 1'b0, 16'h0051},
    '{8'h98, 24'h000011, 1'b0, 1'b0, 16'h0052},
    '{8'h98, 24'h000012, 1'b0, 1'b0, 16'h0059},
    '{8'h98, 24'h000013, 1'b0, 1'b0, 16'h0000},
    '{8'hFF, 24'h001234, 1'b0, 1'b0, 16'h3C5A}};

  // Free-running 100 MHz clock
  always #5 clk_sys_in = ~clk_sys_in;

  flash_status_otp_id_readout #(.MAKER_CODE(MAKER), .PART_CODE(PART), .UNIQUE_ID(UID)) flash_status_otp_id_readout_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .addr_in(addr), .data_in(wdata), .data_out(rdata), .data_oe_n_out(),
    .pgm_volt_ok_in(pgm_volt_ok_in), .blk_locked_in(blk_locked_in), .blk_lockdn_in(blk_lockdn_in),
    .array_data_in(array_data_in));
  host_model host_model_i (
    .clk_sys_in(clk_sys_in), .rdata_in(rdata), .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n),
    .addr_out(addr), .wdata_out(wdata));

  // Compare one value and count it
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] q);
    comparisons++;
    if (q !== e) begin
      $display("MISMATCH %s expected %h seen %h", name, e, q);
      num_errors++;
    end
  endtask
  // Print the counts and the verdict, then end the run
  task automatic stop_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // OTP program, then status until ready, sticky errors, clear, read back
  task automatic otp_case(input logic [15:0] a, d, input logic [7:0] sr, input logic [15:0] w, input logic bsy,
    input logic [7:0] c = CMD_OTP_PROG);
    logic [15:0] q;
    int          n;
    host_model_i.wr(24'h000000, {8'h00, c});
    host_model_i.wr({8'h00, a}, d);
    host_model_i.rd(24'h000000, q);
    if (bsy) chk("busy bit", 16'h0000, {15'h0000, q[7]});
    n = 0;
    while (q[7] !== 1'b1 && n < 100) begin
      host_model_i.rd(24'h000000, q);
      n++;
    end
    chk("status", {8'h00, sr}, q);
    host_model_i.wr(24'h000000, {8'h00, CMD_READ_STATUS});
    host_model_i.rd(24'h000000, q);
    chk("held status", {8'h00, sr}, q);
    host_model_i.wr(24'h000000, {8'h00, CMD_CLEAR_STATUS});
    host_model_i.wr(24'h000000, {8'h00, CMD_READ_STATUS});
    host_model_i.rd(24'h000000, q);
    chk("cleared status", {8'h00, SR_RESET}, q);
    host_model_i.wr(24'h000000, {8'h00, CMD_READ_ID});
    host_model_i.rd({8'h00, a}, q);
    chk("otp word", w, q);
  endtask

  // Table of plain reads, then the programming and locking cases
  initial begin
    rst_in = 1'b1;
    pgm_volt_ok_in = 1'b1;
    blk_locked_in = 1'b0;
    blk_lockdn_in = 1'b0;
    array_data_in = 16'h0000;
    repeat (16) @(negedge clk_sys_in);
    rst_in = 1'b0;
    foreach (rows[i]) begin
      blk_locked_in = rows[i].lk;
      blk_lockdn_in = rows[i].ld;
      array_data_in = (rows[i].cmd == CMD_READ_ARRAY) ? rows[i].e : ~rows[i].e;
      host_model_i.wr(24'h000000, {8'h00, rows[i].cmd});
      repeat (2) begin
        host_model_i.rd(rows[i].a, got);
        chk("read word", rows[i].e, got);
      end
    end
    otp_case(16'h008A, 16'hFF0F, 8'h80, 16'hFF0F, 1'b1);
    otp_case(16'h008A, 16'hF0FF, 8'h80, 16'hF00F, 1'b0);
    otp_case(16'h0081, 16'h0000, 8'hB0, UID[15:0], 1'b0);
    otp_case(16'h0005, 16'h0000, 8'h90, {8'h00, CONFIG_RESET}, 1'b0);
    pgm_volt_ok_in = 1'b0;
    otp_case(16'h008C, 16'h0000, 8'h98, 16'hFFFF, 1'b0);
    pgm_volt_ok_in = 1'b1;
    otp_case(16'h0089, 16'hFFDF, 8'h80, 16'hFFDF, 1'b0);
    otp_case(16'h00B2, 16'h0000, 8'hB0, 16'hFFFF, 1'b0);
    otp_case(16'h00AA, 16'h1234, 8'h80, 16'h1234, 1'b0);
    otp_case(16'h0080, 16'hFFFD, 8'h80, 16'h00FC, 1'b0);
    otp_case(16'h0085, 16'h0000, 8'hB0, 16'hFFFF, 1'b0);
    blk_locked_in = 1'b1;
    otp_case(16'h0002, 16'h0000, 8'h92, 16'h0001, 1'b0, CMD_WORD_PROG);
    stop_test();
  end
  // Watchdog well beyond the expected run of about 1100 cycles
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule
